// ---- rtl/dcm_pkg.sv ----
// Shared constants and types of the dual clock operating mode control
package dcm_pkg;

    // ****************************************************************
    // Register map: printed offsets are word indices
    // ****************************************************************
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam logic [7:0]  IDX_SLEEP_CMD   = 8'h15;
    localparam logic [7:0]  IDX_OP_MODE     = 8'h17;
    localparam logic [7:0]  IDX_MODE_STATUS = 8'h18;
    localparam logic [7:0]  ADDR_SLEEP_CMD  = {IDX_SLEEP_CMD[5:0], 2'b00};
    localparam logic [7:0]  ADDR_OP_MODE    = {IDX_OP_MODE[5:0], 2'b00};
    localparam logic [7:0]  ADDR_STATUS     = {IDX_MODE_STATUS[5:0], 2'b00};

    // ****************************************************************
    // Field layout of operating_mode_control
    // ****************************************************************
    localparam int          CSEL_BIT        = 7;
    localparam int          DIV_HI          = 6;
    localparam int          DIV_LO          = 4;
    localparam int          RTC_EN_BIT      = 3;
    localparam int          RTC_CLR_BIT     = 2;
    localparam logic        CSEL_RST        = 1'b1;
    localparam logic [2:0]  DIV_RST         = 3'h0;
    localparam logic        RTC_EN_RST      = 1'b1;
    localparam logic [7:0]  SLEEP_KEY       = 8'h5A;

    // ****************************************************************
    // Widths and stabilisation counts, in oscillator cycles
    // ****************************************************************
    localparam int          DIV_CNT_W       = 7;
    localparam int          PRESC_W         = 14;
    localparam int          STAB_W          = 11;
    localparam logic [10:0] FAST_STABLE_CYC = 11'd512;
    localparam logic [10:0] XTAL_STABLE_CYC = 11'd1024;
    localparam logic [10:0] RC_STABLE_CYC   = 11'd4;
    localparam int          WAKE_W          = 5;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [5:0] {
        DCM_NORMAL  = 6'b000001,
        DCM_SLOW    = 6'b000010,
        DCM_WARMUP  = 6'b000100,
        DCM_STANDBY = 6'b001000,
        DCM_HALT    = 6'b010000,
        DCM_WAKING  = 6'b100000
    } dcm_state_t;

    typedef struct packed {
        logic key_change;
        logic slow_tmr_irq;
        logic fast_periodic_timer;
        logic slow_periodic_timer;
        logic ext_irq;
    } dcm_wake_t;

    typedef struct packed {
        logic fast_osc_en;
        logic slow_osc_en;
        logic cpu_run;
        logic cpu_clk_tick;
        logic divided_fast_tick;
        logic rtc_tick;
    } dcm_clk_ctl_t;

endpackage : dcm_pkg

// ---- rtl/dcm_sync.sv ----
// Three-stage input synchroniser with agreement filter and rise pulse
`timescale 1ns/100ps
module dcm_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // Asynchronous input
    input  wire logic [W-1:0] din,
    // Filtered level and rising pulse
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] level_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            level_r <= '0;
        end else begin
            level_r <= (s2_r & s3_r) | (level_r & (s2_r | s3_r));
        end
    end

    assign level = level_r;
    assign rise  = s2_r & s3_r & ~level_r;

endmodule : dcm_sync

// ---- rtl/dcm_ctrl.sv ----
// Dual clock operating mode controller with APB register access
`timescale 1ns/100ps
module dcm_ctrl (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         sys_rst,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [dcm_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [dcm_pkg::DATA_W-1:0]   pwdata,
    output logic      [dcm_pkg::DATA_W-1:0]   prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Oscillator pins and source strap
    input  wire logic                         fast_osc_clk,
    input  wire logic                         slow_osc_clk,
    input  wire logic                         slow_src_xtal,
    // Wake-up sources
    input  wire dcm_pkg::dcm_wake_t           wake_src,
    // Clock control and prescaler taps
    output dcm_pkg::dcm_clk_ctl_t             clk_ctl,
    output logic      [dcm_pkg::PRESC_W-1:0]  rtc_taps,
    output dcm_pkg::dcm_state_t               op_state
);

    import dcm_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    dcm_state_t               state_r;
    dcm_state_t               state_nxt;
    logic                     csel_r;
    logic [2:0]               div_r;
    logic                     rtc_en_r;
    logic                     xtal_r;
    logic                     strap_taken_r;
    logic [DIV_CNT_W-1:0]     div_cnt_r;
    logic [DIV_CNT_W-1:0]     div_mask;
    logic [PRESC_W-1:0]       presc_r;
    logic [STAB_W-1:0]        stab_cnt_r;
    logic [STAB_W-1:0]        stab_goal;
    logic                     stab_done;
    logic                     wait_fast;
    logic [DATA_W-1:0]        prdata_r;
    logic                     fast_tick_r;
    logic                     cpu_tick_r;
    logic                     rtc_tick_r;
    logic                     osc_lvl_unused;
    logic                     fast_rise;
    logic                     slow_rise;
    logic [1:0]               osc_lvl;
    logic [1:0]               osc_rise;
    dcm_wake_t                wake_lvl;
    dcm_wake_t                wake_rise;
    logic                     wr_en;
    logic                     rd_setup;
    logic                     wr_mode;
    logic                     wr_sleep;
    logic                     sleep_go;
    logic                     rtc_clear;
    logic                     wake_any;
    logic                     fast_on;
    logic                     slow_on;
    logic                     mapped;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    dcm_sync #(
        .W      (2)
    ) u_osc_sync (
        .clk    (clk),
        .sys_rst(sys_rst),
        .din    ({fast_osc_clk, slow_osc_clk}),
        .level  (osc_lvl),
        .rise   (osc_rise)
    );

    dcm_sync #(
        .W      (WAKE_W)
    ) u_wake_sync (
        .clk    (clk),
        .sys_rst(sys_rst),
        .din    (wake_src),
        .level  (wake_lvl),
        .rise   (wake_rise)
    );

    // Edges only count while the oscillator is enabled
    assign fast_rise      = osc_rise[1] & fast_on;
    assign slow_rise      = osc_rise[0] & slow_on;
    assign osc_lvl_unused = ^osc_lvl;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    assign wr_en    = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign mapped   = (paddr == ADDR_SLEEP_CMD) | (paddr == ADDR_OP_MODE)
                    | (paddr == ADDR_STATUS);
    assign wr_mode  = wr_en & (paddr == ADDR_OP_MODE);
    assign wr_sleep = wr_en & (paddr == ADDR_SLEEP_CMD);
    // Only the exact key arms sleep, and only from normal or slow mode, not warm-up
    assign sleep_go = wr_sleep & (pwdata[7:0] == SLEEP_KEY)
                    & ((state_r == DCM_NORMAL)
                    | (state_r == DCM_SLOW));
    assign rtc_clear = wr_mode & ~pwdata[RTC_CLR_BIT];

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ****************************************************************
    // Mode register fields
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            csel_r   <= CSEL_RST;
            div_r    <= DIV_RST;
            rtc_en_r <= RTC_EN_RST;
        end else if (wr_mode) begin
            csel_r   <= pwdata[CSEL_BIT];
            div_r    <= pwdata[DIV_HI:DIV_LO];
            rtc_en_r <= pwdata[RTC_EN_BIT];
        end
    end

    // Strap is caught after release, never under reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strap_taken_r <= 1'b0;
            xtal_r        <= 1'b0;
        end else if (!strap_taken_r) begin
            strap_taken_r <= 1'b1;
            xtal_r        <= slow_src_xtal;
        end
    end

    // Read data registered in the setup cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata_r <= '0;
        end else if (rd_setup) begin
            prdata_r <= '0;
            if (paddr == ADDR_OP_MODE) begin
                prdata_r[CSEL_BIT]       <= csel_r;
                prdata_r[DIV_HI:DIV_LO]  <= div_r;
                prdata_r[RTC_EN_BIT]     <= rtc_en_r;
                prdata_r[RTC_CLR_BIT]    <= 1'b1;
            end else if (paddr == ADDR_STATUS) begin
                prdata_r[5:0]            <= state_r;
                prdata_r[6]              <= xtal_r;
            end
        end
    end

    assign prdata = prdata_r;

    // ****************************************************************
    // Mode sequencer
    // ****************************************************************
    assign wake_any = (state_r == DCM_HALT)
                    ? (wake_rise.key_change
                    | wake_rise.ext_irq)
                    : (|wake_rise);

    // Fast warm-up targets normal, otherwise slow source wait
    assign wait_fast = (state_r == DCM_WARMUP) | csel_r;
    assign stab_goal = wait_fast ? FAST_STABLE_CYC
                     : (xtal_r ? XTAL_STABLE_CYC
                     : RC_STABLE_CYC);
    assign stab_done = (stab_cnt_r == stab_goal);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            DCM_NORMAL: begin
                if (sleep_go) begin
                    state_nxt = rtc_en_r ? DCM_STANDBY
                              : DCM_HALT;
                end else if (wr_mode && !pwdata[CSEL_BIT]) begin
                    state_nxt = DCM_SLOW;
                end
            end
            DCM_SLOW: begin
                if (sleep_go) begin
                    state_nxt = rtc_en_r ? DCM_STANDBY
                              : DCM_HALT;
                end else if (wr_mode && pwdata[CSEL_BIT]) begin
                    state_nxt = DCM_WARMUP;
                end
            end
            DCM_WARMUP: begin
                if (!csel_r) begin
                    state_nxt = DCM_SLOW;
                end else if (stab_done) begin
                    state_nxt = DCM_NORMAL;
                end
            end
            DCM_STANDBY,
            DCM_HALT: begin
                if (wake_any) begin
                    state_nxt = DCM_WAKING;
                end
            end
            DCM_WAKING: begin
                if (stab_done) begin
                    state_nxt = csel_r ? DCM_NORMAL
                              : DCM_SLOW;
                end
            end
            default: begin
                state_nxt = DCM_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= DCM_NORMAL;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Counts edges of whichever source is being awaited
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stab_cnt_r <= '0;
        end else if (state_nxt != state_r) begin
            stab_cnt_r <= '0;
        end else if ((state_r == DCM_WARMUP) || (state_r == DCM_WAKING)) begin
            if (!stab_done && (wait_fast ? fast_rise : slow_rise)) begin
                stab_cnt_r <= stab_cnt_r + 1'b1;
            end
        end
    end

    // ****************************************************************
    // Oscillator enables
    // ****************************************************************
    always_comb begin
        unique case (state_r)
            DCM_NORMAL: fast_on = 1'b1;
            DCM_WARMUP: fast_on = 1'b1;
            DCM_WAKING: fast_on = csel_r;
            default:    fast_on = 1'b0;
        endcase
    end

    // In normal mode the slow oscillator follows the prescaler enable
    always_comb begin
        unique case (state_r)
            DCM_NORMAL: slow_on = rtc_en_r;
            DCM_HALT:   slow_on = 1'b0;
            default:    slow_on = 1'b1;
        endcase
    end

    // ****************************************************************
    // Fast clock divider: tick on every 2^N-th fast edge
    // ****************************************************************
    assign div_mask = DIV_CNT_W'((8'h01 << div_r) - 8'h01);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_cnt_r <= '0;
        end else if (!fast_on) begin
            div_cnt_r <= '0;
        end else if (fast_rise) begin
            div_cnt_r <= div_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fast_tick_r <= 1'b0;
        end else begin
            fast_tick_r <= fast_rise
                         & ((div_cnt_r & div_mask) == div_mask);
        end
    end

    // CPU ticks stop while asleep and until the source is stable
    // Keyed on the next state so no tick leaks into the first sleep cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cpu_tick_r <= 1'b0;
        end else begin
            unique case (state_nxt)
                DCM_NORMAL: cpu_tick_r <= fast_rise
                          & ((div_cnt_r & div_mask)
                          == div_mask);
                DCM_SLOW,
                DCM_WARMUP: cpu_tick_r <= slow_rise;
                default:    cpu_tick_r <= 1'b0;
            endcase
        end
    end

    // ****************************************************************
    // Real-time-clock prescaler
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            presc_r    <= '0;
            rtc_tick_r <= 1'b0;
        end else if (rtc_clear) begin
            presc_r    <= '0;
            rtc_tick_r <= 1'b0;
        end else begin
            rtc_tick_r <= slow_rise & rtc_en_r;
            if (slow_rise && rtc_en_r) begin
                presc_r <= presc_r + 1'b1;
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign clk_ctl.fast_osc_en       = fast_on;
    assign clk_ctl.slow_osc_en       = slow_on;
    assign clk_ctl.cpu_run           = (state_r == DCM_NORMAL)
                                     | (state_r == DCM_SLOW)
                                     | (state_r == DCM_WARMUP);
    assign clk_ctl.cpu_clk_tick      = cpu_tick_r;
    assign clk_ctl.divided_fast_tick = fast_tick_r;
    assign clk_ctl.rtc_tick          = rtc_tick_r;
    assign rtc_taps                  = presc_r;
    assign op_state                  = state_r;

endmodule : dcm_ctrl

// ---- testbench/dcm_ctrl_assertions.sv ----
// Concurrent checks on the ports of the operating mode controller
`timescale 1ns/100ps
module dcm_ctrl_assertions (
    // Clock and reset
    input wire logic                         clk,
    input wire logic                         sys_rst,
    // APB slave
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire logic [dcm_pkg::ADDR_W-1:0]   paddr,
    input wire logic [dcm_pkg::DATA_W-1:0]   pwdata,
    input wire logic [dcm_pkg::DATA_W-1:0]   prdata,
    input wire logic                         pready,
    input wire logic                         pslverr,
    // Oscillators, strap and wake sources
    input wire logic                         fast_osc_clk,
    input wire logic                         slow_osc_clk,
    input wire logic                         slow_src_xtal,
    input wire dcm_pkg::dcm_wake_t           wake_src,
    // Clock control and state
    input wire dcm_pkg::dcm_clk_ctl_t        clk_ctl,
    input wire logic [dcm_pkg::PRESC_W-1:0]  rtc_taps,
    input wire dcm_pkg::dcm_state_t          op_state
);
    import dcm_pkg::*;
    logic        fast_q;
    logic [11:0] fe_cnt;
    wire         wr_acc = psel && penable && pwrite;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Pin edges seen while waiting; sync latency gives a few edges slack
    always_ff @(posedge clk) begin
        fast_q <= fast_osc_clk;
    end
    always_ff @(posedge clk) begin
        if (sys_rst || !(op_state inside {DCM_WARMUP, DCM_WAKING}))
            fe_cnt <= 12'h000;
        else if (fast_osc_clk && !fast_q)
            fe_cnt <= fe_cnt + 12'h001;
    end
    reset_normal_a: assert property ($fell(sys_rst) |->
        op_state == DCM_NORMAL && clk_ctl.cpu_run && clk_ctl.fast_osc_en)
        else $error("wrong state after reset");
    clear_reads_a: assert property (psel && penable && !pwrite &&
        paddr == ADDR_OP_MODE |-> prdata[2] && prdata[31:8] == 24'h0)
        else $error("mode read bit 2 not high");
    slow_entry_a: assert property (wr_acc && paddr == ADDR_OP_MODE &&
        !pwdata[7] && op_state == DCM_NORMAL |-> ##[1:2] op_state == DCM_SLOW)
        else $error("select 0 did not enter slow");
    standby_entry_a: assert property (wr_acc && paddr == ADDR_SLEEP_CMD &&
        pwdata[7:0] == SLEEP_KEY && op_state == DCM_NORMAL && clk_ctl.slow_osc_en
        |-> ##[1:2] op_state == DCM_STANDBY) else $error("no standby");
    halt_entry_a: assert property (wr_acc && paddr == ADDR_SLEEP_CMD &&
        pwdata[7:0] == SLEEP_KEY && op_state == DCM_NORMAL && !clk_ctl.slow_osc_en
        |-> ##[1:2] op_state == DCM_HALT) else $error("no halt");
    bad_key_a: assert property (wr_acc && paddr == ADDR_SLEEP_CMD &&
        pwdata[7:0] != SLEEP_KEY && op_state inside {DCM_NORMAL, DCM_SLOW}
        |-> ##2 !(op_state inside {DCM_STANDBY, DCM_HALT}))
        else $error("wrong sleep value changed mode");
    standby_clk_a: assert property (op_state == DCM_STANDBY |->
        !clk_ctl.fast_osc_en && clk_ctl.slow_osc_en && !clk_ctl.cpu_run &&
        !clk_ctl.cpu_clk_tick) else $error("standby clock state wrong");
    halt_clk_a: assert property (op_state == DCM_HALT |->
        !clk_ctl.fast_osc_en && !clk_ctl.slow_osc_en && !clk_ctl.cpu_run &&
        !clk_ctl.rtc_tick) else $error("halt clock state wrong");
    halt_hold_a: assert property ((op_state == DCM_HALT &&
        !wake_src.key_change && !wake_src.ext_irq) [*6] |=> op_state == DCM_HALT)
        else $error("halt left without its wake source");
    warm_count_a: assert property (op_state == DCM_NORMAL &&
        $past(op_state) inside {DCM_WARMUP, DCM_WAKING}
        |-> fe_cnt inside {[12'd508:12'd516]}) else $error("warmup length");
    wake_target_a: assert property ($past(op_state) == DCM_WAKING &&
        op_state != DCM_WAKING |-> op_state inside {DCM_NORMAL, DCM_SLOW})
        else $error("wake left to wrong mode");
    rtc_clear_a: assert property (wr_acc && paddr == ADDR_OP_MODE &&
        !pwdata[2] |-> ##[1:2] rtc_taps == '0) else $error("prescaler not cleared");
    cover property (op_state == DCM_STANDBY ##1 op_state == DCM_WAKING);
    cover property (op_state == DCM_HALT ##1 op_state == DCM_WAKING);
    cover property (op_state == DCM_WARMUP ##1 op_state == DCM_NORMAL);
endmodule : dcm_ctrl_assertions

bind dcm_ctrl dcm_ctrl_assertions u_dcm_ctrl_assertions (
    .clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fast_osc_clk, .slow_osc_clk, .slow_src_xtal,
    .wake_src, .clk_ctl, .rtc_taps, .op_state
);

// ---- testbench/tb_top.sv ----
// Self-checking testbench for the operating mode controller
`timescale 1ns/100ps
module tb_top;
    import dcm_pkg::*;
    logic                clk, sys_rst, psel, penable, pwrite, er;
    logic [ADDR_W-1:0]   paddr;
    logic [DATA_W-1:0]   pwdata, prdata, rd;
    logic                pready, pslverr, fast_osc_clk, slow_osc_clk;
    logic                slow_src_xtal;
    dcm_wake_t           wake_src;
    dcm_clk_ctl_t        clk_ctl;
    logic [PRESC_W-1:0]  rtc_taps, t0;
    dcm_state_t          op_state;
    int                  num_errors, num_checks, fcnt, tk, fe, se, ex;
    int                  dt, rt;

    dcm_ctrl u_dcm_ctrl (
        .clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .fast_osc_clk, .slow_osc_clk, .slow_src_xtal,
        .wake_src, .clk_ctl, .rtc_taps, .op_state
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Oscillators stand still at 0 while their enable is low
    always @(posedge clk) begin
        if (sys_rst) begin
            {fcnt, fast_osc_clk, slow_osc_clk} <= '0;
        end else begin
            fcnt <= fcnt + 1;
            if (fcnt % 4 == 3)
                fast_osc_clk <= (clk_ctl.fast_osc_en === 1'b1) ? ~fast_osc_clk : 1'b0;
            if (fcnt % 16 == 15)
                slow_osc_clk <= (clk_ctl.slow_osc_en === 1'b1) ? ~slow_osc_clk : 1'b0;
        end
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_st(input dcm_state_t s, input int lim);
        int n;
        n = 0;
        @(negedge clk);
        while (op_state !== s && n < lim) begin
            @(negedge clk);
            n++;
        end
        check({26'h0, op_state}, {26'h0, s});
    endtask : wait_st

    task automatic count(input int n);
        logic pf, ps;
        tk = 0;
        dt = 0;
        rt = 0;
        fe = 0;
        se = 0;
        pf = fast_osc_clk;
        ps = slow_osc_clk;
        repeat (n) begin
            @(negedge clk);
            tk += int'(clk_ctl.cpu_clk_tick === 1'b1);
            dt += int'(clk_ctl.divided_fast_tick === 1'b1);
            rt += int'(clk_ctl.rtc_tick === 1'b1);
            fe += int'(fast_osc_clk === 1'b1 && pf === 1'b0);
            se += int'(slow_osc_clk === 1'b1 && ps === 1'b0);
            pf = fast_osc_clk;
            ps = slow_osc_clk;
        end
    endtask : count

    task automatic pulse(input int i);
        @(posedge clk);
        wake_src <= dcm_wake_t'(5'h01 << i);
        repeat (8) @(posedge clk);
        wake_src <= dcm_wake_t'(5'h00);
    endtask : pulse

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    // Rough run is near 65k cycles
    initial begin
        repeat (95000) @(posedge clk);
        num_errors++;
        close_out();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {sys_rst, psel, penable, pwrite} = 4'h8;
        {paddr, pwdata, slow_src_xtal, num_errors, num_checks} = '0;
        wake_src = dcm_wake_t'(5'h00);
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        wait_st(DCM_NORMAL, 0);
        apb(1'b0, ADDR_OP_MODE, 32'h0);
        check(rd, 32'h8C);
        apb(1'b0, ADDR_SLEEP_CMD, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd, 32'h01);
        apb(1'b0, 8'h7C, 32'h0);
        check({31'h0, er}, 32'h1);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, ADDR_OP_MODE, 32'h8C | (32'(c) << 4));
            count(2048);
            ex = fe >> c;
            check(32'(tk >= ex - 1 && tk <= ex + 1), 32'h1);
            check(32'(dt >= ex - 1 && dt <= ex + 1), 32'h1);
        end
        t0 = rtc_taps;
        count(640);
        check(32'(rtc_taps - t0 >= 19 && rtc_taps - t0 <= 21), 32'h1);
        check(32'(rt >= se - 1 && rt <= se + 1), 32'h1);
        apb(1'b1, ADDR_OP_MODE, 32'h88);
        @(negedge clk);
        check(32'(rtc_taps < 2), 32'h1);
        apb(1'b1, ADDR_OP_MODE, 32'h84);
        t0 = rtc_taps;
        count(640);
        check({18'h0, rtc_taps}, {18'h0, t0});
        check(rt, 32'h0);
        $display("test divider and prescaler done");
        apb(1'b1, ADDR_OP_MODE, 32'h8C);
        apb(1'b1, ADDR_SLEEP_CMD, 32'hA5);
        repeat (160) @(negedge clk);
        check({26'h0, op_state}, {26'h0, DCM_NORMAL});
        apb(1'b1, ADDR_OP_MODE, 32'h0C);
        wait_st(DCM_SLOW, 5);
        check({31'h0, clk_ctl.fast_osc_en}, 32'h0);
        count(2048);
        check(32'(tk >= se - 2 && tk <= se + 2 && se > 50), 32'h1);
        apb(1'b1, ADDR_SLEEP_CMD, 32'h5A);
        wait_st(DCM_STANDBY, 5);
        pulse(1);
        wait_st(DCM_SLOW, 2000);
        apb(1'b1, ADDR_OP_MODE, 32'h8C);
        wait_st(DCM_WARMUP, 5);
        wait_st(DCM_NORMAL, 6000);
        $display("test slow mode done");
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, ADDR_SLEEP_CMD, 32'h5A);
            wait_st(DCM_STANDBY, 5);
            check({31'h0, clk_ctl.cpu_run}, 32'h0);
            pulse(i);
            wait_st(DCM_NORMAL, 6000);
        end
        $display("test standby done");
        apb(1'b1, ADDR_OP_MODE, 32'h84);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, ADDR_SLEEP_CMD, 32'h5A);
            wait_st(DCM_HALT, 5);
            pulse(i);
            repeat (20) @(negedge clk);
            if (i inside {1, 2, 3}) begin
                check({26'h0, op_state}, {26'h0, DCM_HALT});
                pulse(0);
            end
            wait_st(DCM_NORMAL, 6000);
        end
        $display("test halt done");
        close_out();
    end
endmodule : tb_top
